// ### rtl/qrw_pkg.sv
package qrw_pkg;
   // Opcodes decoded by the front-end
   localparam logic [7:0] OP_QUAD_READ = 8'hEB;
   localparam logic [7:0] OP_WORD_READ = 8'hE7;
   localparam logic [7:0] OP_OCTAL_READ = 8'hE3;
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_MODE_RESET = 8'hFF;
   localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
   localparam logic [7:0] OP_WAKE = 8'hAB;

   // Phase lengths in serial clocks, minus one; dummy lengths are full counts
   localparam logic [2:0] OPCODE_LAST = 3'h7;
   localparam logic [2:0] ADDR_LAST = 3'h5;
   localparam logic [2:0] MODE_LAST = 3'h1;
   localparam logic [2:0] WRAP_ARG_LAST = 3'h7;
   localparam logic [2:0] DUMMY_QUAD = 3'h4;
   localparam logic [2:0] DUMMY_WORD = 3'h2;
   localparam logic [2:0] DUMMY_OCTAL = 3'h0;

   // Mode byte and wrap field layout
   localparam logic [1:0] CONT_SELECT_KEEP = 2'h2;
   localparam int CONT_PAIR_LSB = 4;
   localparam int WRAP_FIELD_LSB = 4;
   localparam logic [2:0] WRAP_RESET = 3'h1;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam int FOUR_LINE_ENABLE_POS = 1;

   // Register port map
   localparam logic [3:0] REG_SECOND_STATUS = 4'h0;
   localparam logic [3:0] REG_VOLATILE = 4'h4;
   localparam logic [3:0] REG_STATE = 4'h8;
   localparam logic [7:0] SECOND_STATUS_RESET = 8'h00;
   localparam logic [7:0] READ_PARAM_RESET = 8'h00;

   // Timing, core clock 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int RESET_SELECT_HOLD_NS = 3;
   localparam int RCH_CYC_RAW = (RESET_SELECT_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] RCH_CYC = 4'((RCH_CYC_RAW < 1) ? 1 : RCH_CYC_RAW);
   localparam int WAKE_RELEASE_US = 3;
   localparam logic [15:0] WAKE_CYC = 16'(WAKE_RELEASE_US * CLK_MHZ);
   localparam int RESET_RECOVERY_US = 30;
   localparam int RESET_RECOVERY_CYC = RESET_RECOVERY_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAP_ARG, ST_IGNORE
   } qrw_state_t;
endpackage

// ### rtl/qrw_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Synchronised view of the serial link inside the core clock domain
interface qrw_link_if;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_start;
   logic sel_end;
   logic [3:0] io_in;
   modport src (output sclk_rise, sclk_fall, sel_start, sel_end, io_in);
   modport dst (input sclk_rise, sclk_fall, sel_start, sel_end, io_in);
endinterface
`default_nettype wire

// ### rtl/qrw_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module qrw_pin_sync (
   input wire logic i_core_clk, // Core clock
   input wire logic i_reset_n, // Async reset, active low
   input wire logic i_sclk, // Serial clock pin
   input wire logic i_sel_n, // Select pin, active low
   input wire logic [3:0] i_io, // Data line inputs
   qrw_link_if.src link // Synchronised events
);
   logic [5:0] meta;
   logic [5:0] sync;
   logic [5:0] next_meta;
   logic [5:0] next_sync;
   logic sclk_q;
   logic sel_n_q;
   logic next_sclk_q;
   logic next_sel_n_q;

   // Two stages per pin; only the second stage feeds edge detection
   always_comb begin
      next_meta = {i_sel_n, i_sclk, i_io};
      next_sync = meta;
      next_sclk_q = sync[4];
      next_sel_n_q = sync[5];
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta <= 6'h20;
         sync <= 6'h20;
         sclk_q <= 1'b0;
         sel_n_q <= 1'b1;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         sclk_q <= next_sclk_q;
         sel_n_q <= next_sel_n_q;
      end
   end

   // Edges are gated by select so a free-running clock outside frames is harmless
   assign link.sclk_rise = sync[4] & ~sclk_q & ~sync[5];
   assign link.sclk_fall = ~sync[4] & sclk_q & ~sync[5];
   assign link.sel_start = ~sync[5] & sel_n_q;
   assign link.sel_end = sync[5] & ~sel_n_q;
   assign link.io_in = sync[3:0];
endmodule
`default_nettype wire

// ### rtl/qrw_wrap_addr.sv
`timescale 1ns/1ns
`default_nettype none
module qrw_wrap_addr
   import qrw_pkg::*;
(
   input wire logic [23:0] i_addr, // Current byte address
   input wire logic [2:0] i_wrap, // Wrap setting {length field, disable bit}
   output logic [23:0] o_next // Following byte address
);
   logic [23:0] linear;
   logic [23:0] mask;

   // Section of 8 << length bytes, aligned inside the page
   always_comb begin
      linear = i_addr + 24'h000001;
      mask = 24'((24'h000008 << i_wrap[2:1]) - 24'h000001);
      if (!i_wrap[0]) begin
         o_next = (i_addr & ~mask) | (linear & mask);
      end else begin
         o_next = linear;
      end
   end
endmodule
`default_nettype wire

// ### rtl/qrw_top.sv
// Functional notes
// - Wrapped reads restart at aligned section start
// - Wrap disable bit zero enables wrapping
// - Length field selects 8/16/32/64 byte section
// - Set-wrap: 77h, 24 ignored, keep bits 6..4
// - Wrap disabled after power-on
// - Stored wrap applies to later quad reads
// - Quad reads and set-wrap need four-line enable
// - Word read: even address, two dummy clocks
// - Octal word read: aligned, no dummy clocks
// - Mode byte follows address; upper nibble matters
// - Select pair 10 skips next opcode
// - Other pair values need full opcode next
// - Mode reset command clears mode byte outside continuous mode
// - Reset enable then reset, runs at select rise
// - Software reset restores volatile defaults
// - Reset ignored in deep power-down
// - Reset ignored in continuous read mode
// - Quad read: four bits per clock, dummies
`timescale 1ns/1ns
`default_nettype none
module qrw_top
   import qrw_pkg::*;
#(
   parameter int RESET_RECOVERY_CYCLES = qrw_pkg::RESET_RECOVERY_CYC
) (
   input wire logic i_core_clk, // Core clock, 250 MHz
   input wire logic i_reset_n, // Async reset, active low
   input wire logic i_sclk, // Serial clock pin
   input wire logic i_sel_n, // Select pin, active low
   input wire logic [3:0] i_io, // Data lines, input side
   output logic [3:0] o_io, // Data lines, output side
   output logic [3:0] o_io_oe, // Data line enables, high drives
   output logic [23:0] o_mem_addr, // Array byte address
   output logic o_mem_rd, // Array read pulse
   input wire logic [7:0] i_mem_data, // Array byte, valid in the pulse cycle
   output logic o_sw_reset, // Software reset executed, pulse
   input wire logic [3:0] i_reg_addr, // Register address
   input wire logic [31:0] i_reg_wdata, // Register write data
   input wire logic i_reg_wr, // Register write strobe
   input wire logic i_reg_rd, // Register read strobe
   output logic [31:0] o_reg_rdata // Register read data
);
   import qrw_pkg::*;

   localparam logic [15:0] RECOVERY_CYC = 16'(RESET_RECOVERY_CYCLES);

   qrw_link_if link ();
   qrw_state_t state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [7:0] shreg, next_shreg;
   logic [7:0] cmd, next_cmd;
   logic [23:0] addr, next_addr;
   logic [23:0] wrap_next;
   logic [7:0] cont_read_mode_byte, next_cont_read_mode_byte;
   logic cont_mode, next_cont_mode;
   logic [2:0] wrap_setting, next_wrap_setting;
   logic [7:0] second_status_reg, next_second_status_reg;
   logic write_permit_latch, next_write_permit_latch;
   logic [7:0] read_param_field, next_read_param_field;
   logic reset_armed, next_reset_armed;
   logic reset_pending, next_reset_pending;
   logic pd_pending, next_pd_pending;
   logic wake_pending, next_wake_pending;
   logic power_down, next_power_down;
   logic [15:0] recover_cnt, next_recover_cnt;
   logic [15:0] wake_cnt, next_wake_cnt;
   logic [3:0] hold_cnt, next_hold_cnt;
   logic [7:0] data_byte, next_data_byte;
   logic nib_sel, next_nib_sel;
   logic [3:0] next_io, next_io_oe;
   logic next_mem_rd, next_sw_reset;
   logic [31:0] next_reg_rdata;
   logic [2:0] dummy_len;
   logic [7:0] op_in;
   logic [7:0] mode_in;
   logic four_line_ok;

   qrw_pin_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_reset_n (i_reset_n),
      .i_sclk (i_sclk),
      .i_sel_n (i_sel_n),
      .i_io (i_io),
      .link (link)
   );

   qrw_wrap_addr u_wrap (
      .i_addr (addr),
      .i_wrap (wrap_setting),
      .o_next (wrap_next)
   );

   // Dummy clocks per read flavour
   always_comb begin
      unique case (cmd)
         OP_WORD_READ: dummy_len = DUMMY_WORD;
         OP_OCTAL_READ: dummy_len = DUMMY_OCTAL;
         default: dummy_len = DUMMY_QUAD;
      endcase
   end

   assign op_in = {shreg[6:0], link.io_in[0]};
   assign mode_in = {shreg[3:0], link.io_in};
   assign four_line_ok = second_status_reg[FOUR_LINE_ENABLE_POS];

   // Frame sequencing, command decode, data streaming and register port
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shreg = shreg;
      next_cmd = cmd;
      next_addr = addr;
      next_cont_read_mode_byte = cont_read_mode_byte;
      next_cont_mode = cont_mode;
      next_wrap_setting = wrap_setting;
      next_second_status_reg = second_status_reg;
      next_write_permit_latch = write_permit_latch;
      next_read_param_field = read_param_field;
      next_reset_armed = reset_armed;
      next_reset_pending = reset_pending;
      next_pd_pending = pd_pending;
      next_wake_pending = wake_pending;
      next_power_down = power_down;
      next_recover_cnt = (recover_cnt != 16'h0000) ? 16'(recover_cnt - 16'h0001) : recover_cnt;
      next_wake_cnt = (wake_cnt != 16'h0000) ? 16'(wake_cnt - 16'h0001) : wake_cnt;
      next_hold_cnt = (hold_cnt != 4'hF) ? 4'(hold_cnt + 4'h1) : hold_cnt;
      next_data_byte = o_mem_rd ? i_mem_data : data_byte;
      next_nib_sel = nib_sel;
      next_io = o_io;
      next_io_oe = o_io_oe;
      next_mem_rd = 1'b0;
      next_sw_reset = 1'b0;
      next_reg_rdata = 32'h00000000;

      if (link.sel_end) begin
         // Deferred actions run at select rise
         next_state = ST_IDLE;
         next_io_oe = 4'h0;
         if (reset_pending && hold_cnt >= RCH_CYC && !cont_mode && !power_down) begin
            next_wrap_setting = WRAP_RESET;
            next_cont_read_mode_byte = MODE_RESET;
            next_cont_mode = 1'b0;
            next_write_permit_latch = 1'b0;
            next_read_param_field = READ_PARAM_RESET;
            next_recover_cnt = RECOVERY_CYC;
            next_sw_reset = 1'b1;
         end
         if (pd_pending) begin
            next_power_down = 1'b1;
         end
         if (wake_pending) begin
            next_power_down = 1'b0;
            next_wake_cnt = WAKE_CYC;
         end
         next_reset_pending = 1'b0;
         next_pd_pending = 1'b0;
         next_wake_pending = 1'b0;
      end else if (link.sel_start) begin
         next_cnt = 3'h0;
         next_nib_sel = 1'b0;
         if (recover_cnt != 16'h0000 || wake_cnt != 16'h0000) begin
            next_state = ST_IGNORE; // Still recovering, frame is dropped
         end else if (cont_mode) begin
            next_state = ST_ADDR;
         end else begin
            next_state = ST_OPCODE;
         end
      end else if (link.sclk_rise) begin
         next_hold_cnt = 4'h0;
         next_cnt = 3'(cnt + 3'h1);
         unique case (state)
            ST_OPCODE: begin
               next_shreg = op_in;
               if (cnt == OPCODE_LAST) begin
                  next_state = ST_IGNORE;
                  next_cnt = 3'h0;
                  if (power_down) begin
                     next_wake_pending = (op_in == OP_WAKE);
                  end else begin
                     next_reset_armed = (op_in == OP_RESET_ENABLE);
                     unique case (op_in)
                        OP_QUAD_READ, OP_WORD_READ, OP_OCTAL_READ: begin
                           if (four_line_ok) begin
                              next_cmd = op_in;
                              next_state = ST_ADDR;
                           end
                        end
                        OP_SET_WRAP: begin
                           if (four_line_ok) begin
                              next_state = ST_WRAP_ARG;
                           end
                        end
                        OP_RESET: next_reset_pending = reset_armed;
                        OP_MODE_RESET: begin
                           next_cont_read_mode_byte = MODE_RESET;
                           next_cont_mode = 1'b0;
                        end
                        OP_POWER_DOWN: next_pd_pending = 1'b1;
                        default: next_state = ST_IGNORE;
                     endcase
                  end
               end
            end
            ST_ADDR: begin
               next_addr = {addr[19:0], link.io_in};
               if (cnt == ADDR_LAST) begin
                  next_state = ST_MODE;
                  next_cnt = 3'h0;
               end
            end
            ST_MODE: begin
               next_shreg = mode_in;
               if (cnt == MODE_LAST) begin
                  next_cont_read_mode_byte = mode_in;
                  next_cont_mode = (mode_in[CONT_PAIR_LSB +: 2] == CONT_SELECT_KEEP);
                  next_cnt = 3'h0;
                  if (dummy_len == 3'h0) begin
                     next_state = ST_DATA;
                     next_mem_rd = 1'b1;
                  end else begin
                     next_state = ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               if (cnt == 3'(dummy_len - 3'h1)) begin
                  next_state = ST_DATA;
                  next_mem_rd = 1'b1;
               end
            end
            ST_WRAP_ARG: begin
               next_shreg = mode_in;
               if (cnt == WRAP_ARG_LAST) begin
                  next_wrap_setting = mode_in[WRAP_FIELD_LSB +: 3];
                  next_state = ST_IGNORE;
               end
            end
            ST_IDLE, ST_DATA, ST_IGNORE: next_cnt = cnt;
         endcase
      end else if (link.sclk_fall && state == ST_DATA) begin
         // High nibble first; next byte fetched after the low one
         next_io = nib_sel ? data_byte[3:0] : data_byte[7:4];
         next_io_oe = 4'hF;
         next_nib_sel = ~nib_sel;
         if (nib_sel) begin
            next_addr = wrap_next;
            next_mem_rd = 1'b1;
         end
      end

      if (i_reg_wr) begin
         unique case (i_reg_addr)
            REG_SECOND_STATUS: next_second_status_reg = i_reg_wdata[7:0];
            REG_VOLATILE: begin
               next_write_permit_latch = i_reg_wdata[0];
               next_read_param_field = i_reg_wdata[15:8];
            end
            default: next_reg_rdata = 32'h00000000;
         endcase
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_SECOND_STATUS: next_reg_rdata = {24'h000000, second_status_reg};
            REG_VOLATILE: next_reg_rdata = {16'h0000, read_param_field, 7'h00, write_permit_latch};
            REG_STATE: next_reg_rdata = {8'h00, cont_read_mode_byte, 8'h00,
               recover_cnt != 16'h0000, power_down, cont_mode, 2'h0, wrap_setting};
            default: next_reg_rdata = 32'h00000000;
         endcase
      end
   end

   // Registers; wrap setting comes up disabled
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         shreg <= 8'h00;
         cmd <= OP_QUAD_READ;
         addr <= 24'h000000;
         cont_read_mode_byte <= MODE_RESET;
         cont_mode <= 1'b0;
         wrap_setting <= WRAP_RESET;
         second_status_reg <= SECOND_STATUS_RESET;
         write_permit_latch <= 1'b0;
         read_param_field <= READ_PARAM_RESET;
         reset_armed <= 1'b0;
         reset_pending <= 1'b0;
         pd_pending <= 1'b0;
         wake_pending <= 1'b0;
         power_down <= 1'b0;
         recover_cnt <= 16'h0000;
         wake_cnt <= 16'h0000;
         hold_cnt <= 4'h0;
         data_byte <= 8'h00;
         nib_sel <= 1'b0;
         o_io <= 4'h0;
         o_io_oe <= 4'h0;
         o_mem_addr <= 24'h000000;
         o_mem_rd <= 1'b0;
         o_sw_reset <= 1'b0;
         o_reg_rdata <= 32'h00000000;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shreg <= next_shreg;
         cmd <= next_cmd;
         addr <= next_addr;
         cont_read_mode_byte <= next_cont_read_mode_byte;
         cont_mode <= next_cont_mode;
         wrap_setting <= next_wrap_setting;
         second_status_reg <= next_second_status_reg;
         write_permit_latch <= next_write_permit_latch;
         read_param_field <= next_read_param_field;
         reset_armed <= next_reset_armed;
         reset_pending <= next_reset_pending;
         pd_pending <= next_pd_pending;
         wake_pending <= next_wake_pending;
         power_down <= next_power_down;
         recover_cnt <= next_recover_cnt;
         wake_cnt <= next_wake_cnt;
         hold_cnt <= next_hold_cnt;
         data_byte <= next_data_byte;
         nib_sel <= next_nib_sel;
         o_io <= next_io;
         o_io_oe <= next_io_oe;
         o_mem_addr <= next_addr;
         o_mem_rd <= next_mem_rd;
         o_sw_reset <= next_sw_reset;
         o_reg_rdata <= next_reg_rdata;
      end
   end
endmodule
`default_nettype wire

// ### bench/qrw_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host on the serial link; clock idles low between frames
module qrw_host_model
   import qrw_pkg::*;
(
   input wire logic i_core_clk, // Core clock, times the link
   input wire logic [3:0] i_dev_io, // Device data outputs
   input wire logic [3:0] i_dev_oe, // Device data enables
   output logic o_sclk, // Serial clock, 64 ns period
   output logic o_sel_n, // Select, active low
   output logic [3:0] o_line // Resolved data lines
);
   logic [3:0] drv = 4'h0;
   logic hoe = 1'b0;
   logic tgl = 1'b0;
   logic [3:0] nib;
   logic [7:0] rx [4];
   initial begin
      o_sclk = 1'b0;
      o_sel_n = 1'b1;
   end
   // Undriven lines toggle so stale data never passes
   always @(posedge i_core_clk) tgl <= ~tgl;
   assign o_line = hoe ? drv : ((i_dev_oe & i_dev_io) | (~i_dev_oe & (4'h5 ^ {4{tgl}})));
   // One link clock: set while low, sample mid-high
   task automatic cyc(input logic [3:0] v, input logic rel);
      drv <= v;
      repeat (8) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      #1 nib = o_line;
      if (rel) hoe <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b0;
   endtask
   task automatic open_f();
      @(posedge i_core_clk);
      o_sel_n <= 1'b0;
      hoe <= 1'b1;
      repeat (4) @(posedge i_core_clk);
   endtask
   // Select rises well after the last fall
   task automatic close_f();
      repeat (4) @(posedge i_core_clk);
      o_sel_n <= 1'b1;
      hoe <= 1'b0;
      repeat (8) @(posedge i_core_clk);
   endtask
   task automatic send_op(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) cyc({3'h0, b[i]}, 1'b0);
   endtask
   task automatic op(input logic [7:0] b);
      open_f();
      send_op(b);
      close_f();
   endtask
   // Ignored bits are sent non-zero
   task automatic set_wrap(input logic [7:0] w);
      open_f();
      send_op(OP_SET_WRAP);
      repeat (6) cyc(4'hA, 1'b0);
      cyc(w[7:4], 1'b0);
      cyc(w[3:0], 1'b0);
      close_f();
   endtask
   task automatic read(input logic skip, input logic [7:0] opc, input logic [23:0] a, input logic [7:0] m,
                       input int nd);
      logic [3:0] hi;
      open_f();
      if (!skip) send_op(opc);
      for (int i = 5; i >= 0; i--) cyc(a[i*4+:4], 1'b0);
      cyc(m[7:4], 1'b0);
      cyc(m[3:0], 1'b1);
      repeat (nd) cyc(4'h0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         cyc(4'h0, 1'b0);
         hi = nib;
         cyc(4'h0, 1'b0);
         rx[k] = {hi, nib};
      end
      close_f();
   endtask
endmodule
`default_nettype wire

// ### bench/qrw_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the top-level pins
module qrw_top_checker #(
   parameter int RESET_RECOVERY_CYCLES = 20
) (
   input wire logic i_core_clk, // Core clock
   input wire logic i_reset_n, // Async reset, active low
   input wire logic i_sclk, // Serial clock pin
   input wire logic i_sel_n, // Select pin, active low
   input wire logic [3:0] o_io, // Data line outputs
   input wire logic [3:0] o_io_oe, // Data line enables
   input wire logic o_mem_rd, // Array read pulse
   input wire logic o_sw_reset, // Software reset pulse
   input wire logic i_reg_rd, // Register read strobe
   input wire logic [31:0] o_reg_rdata // Register read data
);
   logic [3:0] sel_hi_cnt, next_sel_hi_cnt;
   int rec_cnt, next_rec_cnt;
   // Select-high time saturates; recovery counts down
   always_comb begin
      next_sel_hi_cnt = !i_sel_n ? 4'h0 : ((sel_hi_cnt == 4'hF) ? 4'hF : sel_hi_cnt + 4'h1);
      next_rec_cnt = o_sw_reset ? RESET_RECOVERY_CYCLES : ((rec_cnt > 0) ? rec_cnt - 1 : 0);
   end
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sel_hi_cnt <= 4'h0;
         rec_cnt <= 0;
      end else begin
         sel_hi_cnt <= next_sel_hi_cnt;
         rec_cnt <= next_rec_cnt;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   oe_levels_a: assert property (o_io_oe == 4'h0 || o_io_oe == 4'hF)
      else $error("data enables split");
   oe_release_a: assert property ($rose(i_sel_n) |-> ##[1:8] (o_io_oe == 4'h0))
      else $error("data lines held after select rose");
   idle_quiet_a: assert property ((sel_hi_cnt >= 4'hA) |-> (o_io_oe == 4'h0 && !o_mem_rd && !o_sw_reset))
      else $error("activity while deselected");
   sw_pulse_a: assert property (o_sw_reset |=> !o_sw_reset)
      else $error("reset pulse too long");
   sw_select_a: assert property (o_sw_reset |-> (sel_hi_cnt inside {[4'h1:4'h8]}))
      else $error("reset not tied to select rise");
   oe_start_a: assert property ($rose(o_io_oe[0]) |-> (!i_sel_n && !i_sclk))
      else $error("drive began off a falling clock");
   io_on_fall_a: assert property ((o_io_oe == 4'hF && $past(o_io_oe) == 4'hF && o_io != $past(o_io)) |-> !i_sclk)
      else $error("data changed while clock high");
   mem_pulse_a: assert property (o_mem_rd |=> !o_mem_rd)
      else $error("array read pulse too long");
   recovery_quiet_a: assert property ((rec_cnt > 2) |-> (!o_mem_rd && o_io_oe == 4'h0))
      else $error("frame served during reset recovery");
   rdata_idle_a: assert property (!$past(i_reg_rd) |-> (o_reg_rdata == 32'h0))
      else $error("read data outside its cycle");
endmodule
bind qrw_top qrw_top_checker #(.RESET_RECOVERY_CYCLES(RESET_RECOVERY_CYCLES)) u_qrw_top_checker (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_sel_n(i_sel_n), .o_io(o_io),
   .o_io_oe(o_io_oe), .o_mem_rd(o_mem_rd), .o_sw_reset(o_sw_reset), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata));
`default_nettype wire

// ### bench/qrw_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define QRW_CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module qrw_top_tb;
   import qrw_pkg::*;
   logic clk, i_reset_n, sclk, sel_n, reg_wr, reg_rd, o_mem_rd, o_sw_reset;
   logic [3:0] line, o_io, o_io_oe, reg_addr;
   logic [7:0] mem_data;
   logic [23:0] o_mem_addr;
   logic [31:0] reg_wdata, o_reg_rdata, v;
   logic [15:0] mem_cnt = 16'h0;
   logic [7:0] sw_cnt = 8'h00;
   int num_errors = 0;
   int checked = 0;
   qrw_top #(.RESET_RECOVERY_CYCLES(20)) u_qrw_top (.i_core_clk(clk), .i_reset_n(i_reset_n), .i_sclk(sclk),
      .i_sel_n(sel_n), .i_io(line), .o_io(o_io), .o_io_oe(o_io_oe), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
      .i_mem_data(mem_data), .o_sw_reset(o_sw_reset), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(o_reg_rdata));
   qrw_host_model u_qrw_host_model (.i_core_clk(clk), .i_dev_io(o_io), .i_dev_oe(o_io_oe), .o_sclk(sclk),
      .o_sel_n(sel_n), .o_line(line));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Array stand-in: scrambled low address byte, valid in the pulse cycle
   assign mem_data = o_mem_addr[7:0] ^ 8'h5A;
   always @(posedge clk) begin
      if (o_mem_rd === 1'b1) mem_cnt++;
      if (o_sw_reset === 1'b1) sw_cnt++;
   end
   task automatic op(input logic [7:0] b);
      u_qrw_host_model.op(b);
   endtask
   task automatic rst2();
      op(OP_RESET_ENABLE);
      op(OP_RESET);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = o_reg_rdata;
   endtask
   function automatic logic [31:0] st(input logic [7:0] m, input logic b, p, c, input logic [2:0] w);
      return {8'h00, m, 8'h00, b, p, c, 2'b00, w};
   endfunction
   // Four bytes of one frame, folded into the wrap section
   task automatic rd_check(input logic skip, input logic [7:0] opc, input logic [23:0] a, input logic [7:0] m,
                           input int sec);
      logic [23:0] ea;
      int nd;
      nd = (opc == OP_QUAD_READ) ? DUMMY_QUAD : ((opc == OP_WORD_READ) ? DUMMY_WORD : DUMMY_OCTAL);
      u_qrw_host_model.read(skip, opc, a, m, nd);
      for (int k = 0; k < 4; k++) begin
         ea = (sec == 0) ? a + 24'(k) : ((a & ~24'(sec - 1)) | ((a + 24'(k)) & 24'(sec - 1)));
         `QRW_CHK(u_qrw_host_model.rx[k], ea[7:0] ^ 8'h5A)
      end
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      final_report();
   end
   initial begin
      {i_reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (16) @(posedge clk);
      i_reset_n <= 1'b1;
      reg_read(REG_STATE, v);
      `QRW_CHK(v, st(8'h00, 1'b0, 1'b0, 1'b0, WRAP_RESET))
      reg_read(4'hC, v);
      `QRW_CHK(v, 32'h0)
      u_qrw_host_model.read(1'b0, OP_QUAD_READ, 24'h000010, 8'h00, 4);
      `QRW_CHK(mem_cnt, 16'h0)
      reg_write(REG_SECOND_STATUS, 32'h2);
      reg_read(REG_SECOND_STATUS, v);
      `QRW_CHK(v, 32'h2)
      rd_check(1'b0, OP_QUAD_READ, 24'h00003E, 8'h00, 0);
      $display("test defaults and linear read done");
      for (int l = 0; l < 4; l++) begin
         u_qrw_host_model.set_wrap({1'b1, 2'(l), 1'b0, 4'hF});
         reg_read(REG_STATE, v);
         `QRW_CHK(v, st(8'h00, 1'b0, 1'b0, 1'b0, {2'(l), 1'b0}))
         rd_check(1'b0, OP_QUAD_READ, 24'h001240 + 24'((8 << l) - 2), 8'h00, 8 << l);
         rd_check(1'b0, OP_WORD_READ, 24'h001240 + 24'((8 << l) - 2), 8'h00, 8 << l);
      end
      u_qrw_host_model.set_wrap(8'h10);
      rd_check(1'b0, OP_OCTAL_READ, 24'h000130, 8'h00, 0);
      $display("test wrap lengths done");
      rd_check(1'b0, OP_QUAD_READ, 24'h000200, 8'h2F, 0);
      reg_read(REG_STATE, v);
      `QRW_CHK(v[5], 1'b1)
      rd_check(1'b1, OP_QUAD_READ, 24'h000300, 8'h35, 0);
      reg_read(REG_STATE, v);
      `QRW_CHK({v[21:20], v[5]}, 3'b110)
      op(OP_MODE_RESET);
      reg_read(REG_STATE, v);
      `QRW_CHK(v[23:16], 8'h00)
      rd_check(1'b0, OP_QUAD_READ, 24'h000400, 8'h20, 0);
      op(8'hFF);
      reg_read(REG_STATE, v);
      `QRW_CHK(v[5], 1'b0)
      rd_check(1'b0, OP_QUAD_READ, 24'h000440, 8'h20, 0);
      rst2();
      `QRW_CHK(sw_cnt, 8'h00)
      $display("test continuous mode done");
      op(OP_RESET_ENABLE);
      op(OP_MODE_RESET);
      op(OP_RESET);
      `QRW_CHK(sw_cnt, 8'h00)
      u_qrw_host_model.set_wrap(8'h40);
      reg_write(REG_VOLATILE, 32'h0000AB01);
      rd_check(1'b0, OP_QUAD_READ, 24'h00051E, 8'h35, 32);
      rst2();
      `QRW_CHK(sw_cnt, 8'h01)
      reg_read(REG_STATE, v);
      `QRW_CHK(v, st(8'h00, 1'b1, 1'b0, 1'b0, WRAP_RESET))
      reg_read(REG_VOLATILE, v);
      `QRW_CHK(v, 32'h0)
      reg_read(REG_SECOND_STATUS, v);
      `QRW_CHK(v, 32'h2)
      repeat (25) @(posedge clk);
      reg_read(REG_STATE, v);
      `QRW_CHK(v[7], 1'b0)
      $display("test software reset done");
      op(OP_POWER_DOWN);
      reg_read(REG_STATE, v);
      `QRW_CHK(v[6], 1'b1)
      rst2();
      `QRW_CHK(sw_cnt, 8'h01)
      op(OP_WAKE);
      repeat (int'(WAKE_CYC) + 10) @(posedge clk);
      rst2();
      `QRW_CHK(sw_cnt, 8'h02)
      $display("test power-down done");
      final_report();
   end
endmodule
`default_nettype wire
